// >>> rtl/aomc_top.sv
// operating-mode control of a three-axis accelerometer
// Overview of operation
// - output counts per g: 4096 at 2g, 2048 at 4g, 1024 at 8g
// - axis results are two's complement, zero g reads zero
// - self-test output is real acceleration plus electrostatic stimulus
// - run-enable set means active, clear means standby; bus works in both
// - standby: digital only, analog off, sampling clock stopped
// - active: digital and analog enabled, sampling runs
// - off: everything down, serial bus neither answered nor driven
// - active to standby keeps all register values
// - standby to active resets a designated register subset only
// - sleep and wake are sub-states of active, need run-enable
// - device never holds the serial clock low
// - low-noise bit limits the range to 4g
// - bus ready 500 us plus three clock cycles after supplies are valid
`timescale 1ns/10ps
`default_nettype none
module aomc_top
  import aomc_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CLK_EN_IN,
  input wire logic SUPPLY_OK_IN,
  input wire logic RUN_ENABLE_IN,
  input wire logic SLEEP_REQ_IN,
  input wire logic LOW_NOISE_IN,
  input wire logic [1:0] RANGE_IN,
  input wire logic SELFTEST_IN,
  input wire aomc_axes_t RAW_IN,
  output aomc_axes_t DATA_OUT,
  output logic DATA_VALID_OUT,
  output logic BUS_READY_OUT,
  output logic ANALOG_EN_OUT,
  output logic SAMPLE_CLK_EN_OUT,
  output logic VOLATILE_CLR_OUT,
  output logic SCL_OE_OUT,
  output logic [3:0] STATE_OUT
);
  // supply, run and sleep inputs cross two flops before use
  logic [1:0] sup_s_q, run_s_q, slp_s_q;
  logic sup, run, slp;
  aomc_state_t state_q;
  logic [BOOT_CNT_W-1:0] boot_cnt_q;
  logic [4:0] div_q;
  logic [1:0] eff_range;
  aomc_axes_t fmt;
  logic [DATA_W-1:0] fmt_x, fmt_y, fmt_z;
  logic active;

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sup_s_q <= 2'h0;
      run_s_q <= 2'h0;
      slp_s_q <= 2'h0;
    end else if (CLK_EN_IN) begin
      sup_s_q <= {sup_s_q[0], SUPPLY_OK_IN};
      run_s_q <= {run_s_q[0], RUN_ENABLE_IN};
      slp_s_q <= {slp_s_q[0], SLEEP_REQ_IN};
    end
  end
  assign sup = sup_s_q[1];
  assign run = run_s_q[1];
  assign slp = slp_s_q[1];
  assign active = (state_q == ST_WAKE) || (state_q == ST_SLEEP);

  // boot timer; leaves off BOOT_CYCLES cycles after synced supply, at the bus-ready bound
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      boot_cnt_q <= '0;
    end else if (CLK_EN_IN) begin
      if (!sup) begin
        boot_cnt_q <= '0;
      end else if (state_q == ST_OFF && boot_cnt_q != BOOT_CNT_W'(BOOT_CYCLES - 1)) begin
        boot_cnt_q <= boot_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_q <= ST_OFF;
    end else if (CLK_EN_IN) begin
      if (!sup) begin
        state_q <= ST_OFF;
      end else begin
        case (state_q)
          ST_OFF: begin
            if (boot_cnt_q == BOOT_CNT_W'(BOOT_CYCLES - 1)) state_q <= ST_STANDBY;
          end
          ST_STANDBY: begin
            if (run) state_q <= slp ? ST_SLEEP : ST_WAKE;
          end
          ST_WAKE: begin
            if (!run) state_q <= ST_STANDBY;
            else if (slp) state_q <= ST_SLEEP;
          end
          ST_SLEEP: begin
            if (!run) state_q <= ST_STANDBY;
            else if (!slp) state_q <= ST_WAKE;
          end
          default: state_q <= ST_OFF;
        endcase
      end
    end
  end

  // status outputs from flops
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      BUS_READY_OUT <= 1'b0;
      ANALOG_EN_OUT <= 1'b0;
      VOLATILE_CLR_OUT <= 1'b0;
      STATE_OUT <= ST_OFF;
    end else if (CLK_EN_IN) begin
      BUS_READY_OUT <= sup && (state_q != ST_OFF);
      ANALOG_EN_OUT <= sup && active;
      // one pulse on entry from standby only; leaving active clears nothing
      VOLATILE_CLR_OUT <= sup && (state_q == ST_STANDBY) && run;
      STATE_OUT <= state_q;
    end
  end

  // scl is never pulled, so no stretching ever happens
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) SCL_OE_OUT <= 1'b0;
    else if (CLK_EN_IN) SCL_OE_OUT <= 1'b0;
  end

  // sampling clock divider, halted outside active
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      div_q <= '0;
      SAMPLE_CLK_EN_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (!active) begin
        div_q <= '0;
        SAMPLE_CLK_EN_OUT <= 1'b0;
      end else begin
        div_q <= (div_q == SAMPLE_DIV_LAST) ? 5'h00 : div_q + 5'h01;
        SAMPLE_CLK_EN_OUT <= (div_q == SAMPLE_DIV_LAST);
      end
    end
  end

  // low-noise caps the range at 4g
  assign eff_range = (LOW_NOISE_IN && RANGE_IN == RANGE_8G) ? RANGE_4G : RANGE_IN;

  aomc_axis_fmt u_fx (.raw_in(RAW_IN.x), .range_in(eff_range), .selftest_in(SELFTEST_IN),
    .val_out(fmt_x));
  aomc_axis_fmt u_fy (.raw_in(RAW_IN.y), .range_in(eff_range), .selftest_in(SELFTEST_IN),
    .val_out(fmt_y));
  aomc_axis_fmt u_fz (.raw_in(RAW_IN.z), .range_in(eff_range), .selftest_in(SELFTEST_IN),
    .val_out(fmt_z));
  // one driver for the whole struct
  assign fmt = '{x: fmt_x, y: fmt_y, z: fmt_z};

  // data holds across standby; reset only on entry to active
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      DATA_OUT <= '0;
      DATA_VALID_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (VOLATILE_CLR_OUT) begin
        DATA_OUT <= '0;
        DATA_VALID_OUT <= 1'b0;
      end else if (SAMPLE_CLK_EN_OUT && active) begin
        DATA_OUT <= fmt;
        DATA_VALID_OUT <= 1'b1;
      end
    end
  end

  property p_off_silent;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      CLK_EN_IN && state_q == ST_OFF |=> !BUS_READY_OUT;
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("bus live while off");

  property p_no_stretch;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN) !SCL_OE_OUT;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("scl driven");

  property p_standby_no_sample;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      CLK_EN_IN && state_q == ST_STANDBY |=> !SAMPLE_CLK_EN_OUT && !ANALOG_EN_OUT;
  endproperty
  a_standby_no_sample: assert property (p_standby_no_sample) else $error("standby sampling");

  property p_active_analog;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      CLK_EN_IN && active && sup |=> ANALOG_EN_OUT;
  endproperty
  a_active_analog: assert property (p_active_analog) else $error("analog off in active");

  property p_sleep_needs_run;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      $rose(state_q == ST_SLEEP) |-> $past(run);
  endproperty
  a_sleep_needs_run: assert property (p_sleep_needs_run) else $error("sleep without run");

  property p_standby_keeps;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      state_q == ST_STANDBY && $past(state_q == ST_STANDBY) |-> $stable(DATA_OUT);
  endproperty
  a_standby_keeps: assert property (p_standby_keeps) else $error("data changed in standby");

  property p_entry_clear;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      CLK_EN_IN && VOLATILE_CLR_OUT |=> DATA_OUT == '0 && !DATA_VALID_OUT;
  endproperty
  a_entry_clear: assert property (p_entry_clear) else $error("subset not reset");

  property p_boot_standby;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      $past(state_q) == ST_OFF && state_q != ST_OFF |-> state_q == ST_STANDBY;
  endproperty
  a_boot_standby: assert property (p_boot_standby) else $error("boot not to standby");

  property p_run_active;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      CLK_EN_IN && sup && state_q == ST_STANDBY && run |=> active;
  endproperty
  a_run_active: assert property (p_run_active) else $error("run ignored");

  c_boot: cover property (@(posedge SYS_CLK_IN) $rose(BUS_READY_OUT));
  c_wake: cover property (@(posedge SYS_CLK_IN) $rose(state_q == ST_WAKE));
  c_sleep: cover property (@(posedge SYS_CLK_IN) state_q == ST_WAKE ##1 state_q == ST_SLEEP);
  c_sample: cover property (@(posedge SYS_CLK_IN) $rose(DATA_VALID_OUT));
endmodule // aomc_top
`default_nettype wire

// >>> rtl/aomc_pkg.sv
// shared constants and types for the accelerometer operating-mode control
package aomc_pkg;
  localparam int DATA_W = 14;
  localparam int CLK_PERIOD_NS = 20;
  localparam int BOOT_TIME_US = 500;
  localparam int BOOT_CYCLES = (BOOT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int BOOT_CNT_W = 15;
  localparam int SAMPLE_DIV = 16;
  localparam logic [4:0] SAMPLE_DIV_LAST = 5'(SAMPLE_DIV - 1);
  localparam logic [1:0] RANGE_2G = 2'h0;
  localparam logic [1:0] RANGE_4G = 2'h1;
  localparam logic [1:0] RANGE_8G = 2'h2;
  localparam int SHIFT_2G = 0;
  localparam int SHIFT_4G = 1;
  localparam int SHIFT_8G = 2;
  localparam logic [DATA_W-1:0] ZERO_COUNT = 14'h0000;
  localparam logic [DATA_W-1:0] SELFTEST_STIM = 14'h0100;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_STANDBY = 4'h2,
    ST_WAKE = 4'h4,
    ST_SLEEP = 4'h8
  } aomc_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] x;
    logic [DATA_W-1:0] y;
    logic [DATA_W-1:0] z;
  } aomc_axes_t;
endpackage

// >>> rtl/aomc_axis_fmt.sv
// one axis: range scaling plus self-test stimulus sum
`timescale 1ns/10ps
`default_nettype none
module aomc_axis_fmt
  import aomc_pkg::*;
(
  input wire logic signed [DATA_W-1:0] raw_in,
  input wire logic [1:0] range_in,
  input wire logic selftest_in,
  output logic [DATA_W-1:0] val_out
);
  logic signed [DATA_W-1:0] scaled;
  logic signed [DATA_W-1:0] stim;
  always_comb begin
    // raw is full-precision 2g counts; wider ranges drop resolution
    // stimulus takes the same shift, so range code 3 stays a plain 2g alias
    case (range_in)
      RANGE_4G: begin
        scaled = raw_in >>> SHIFT_4G;
        stim = $signed(SELFTEST_STIM >> SHIFT_4G);
      end
      RANGE_8G: begin
        scaled = raw_in >>> SHIFT_8G;
        stim = $signed(SELFTEST_STIM >> SHIFT_8G);
      end
      default: begin
        scaled = raw_in >>> SHIFT_2G;
        stim = $signed(SELFTEST_STIM >> SHIFT_2G);
      end
    endcase
    if (!selftest_in) stim = $signed(ZERO_COUNT);
    val_out = DATA_W'(scaled + stim);
  end
endmodule // aomc_axis_fmt
`default_nettype wire

// >>> tb/aomc_host_model.sv
// host-side model: run and sleep controls, watches for clock stretch
`timescale 1ns/10ps
`default_nettype none
module aomc_host_model (
  input wire logic clk_in,
  input wire logic bus_ready_in,
  input wire logic scl_oe_in,
  input wire logic run_req_in,
  input wire logic sleep_req_in,
  output logic run_out,
  output logic sleep_out,
  output logic stretch_out
);
  initial begin
    run_out = 1'b0;
    sleep_out = 1'b0;
    stretch_out = 1'b0;
  end
  always @(posedge clk_in) begin
    // no control writes until the device answers on the bus
    if (bus_ready_in === 1'b1) begin
      run_out <= run_req_in;
      sleep_out <= sleep_req_in;
    end
  end
  // watched mid-cycle, once the first reset edge has settled the pin
  always @(negedge clk_in) begin
    if (scl_oe_in !== 1'b0) begin
      stretch_out <= 1'b1;
    end
  end
endmodule // aomc_host_model
`default_nettype wire

// >>> tb/tb.sv
// testbench: boot, mode changes and output formatting
`timescale 1ns/10ps
`default_nettype none
module tb
  import aomc_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sup = 1'b0;
  logic run_req = 1'b0;
  logic slp_req = 1'b0;
  logic ln = 1'b0;
  logic [1:0] rg = RANGE_2G;
  logic st = 1'b0;
  aomc_axes_t raw = '{x: 14'h1000, y: 14'h3000, z: 14'h0000};
  aomc_axes_t data;
  logic valid, ready, analog, sclk, vclr, scl_oe, run, slp, stretch;
  logic [3:0] state;
  int error_cnt = 0;
  int compares = 0;
  always #10 clk = ~clk;
  aomc_host_model host (.clk_in(clk), .bus_ready_in(ready), .scl_oe_in(scl_oe),
    .run_req_in(run_req), .sleep_req_in(slp_req), .run_out(run), .sleep_out(slp),
    .stretch_out(stretch));
  aomc_top dut (.SYS_CLK_IN(clk), .NRST_IN(nrst), .CLK_EN_IN(1'b1), .SUPPLY_OK_IN(sup),
    .RUN_ENABLE_IN(run), .SLEEP_REQ_IN(slp), .LOW_NOISE_IN(ln), .RANGE_IN(rg),
    .SELFTEST_IN(st), .RAW_IN(raw), .DATA_OUT(data), .DATA_VALID_OUT(valid),
    .BUS_READY_OUT(ready), .ANALOG_EN_OUT(analog), .SAMPLE_CLK_EN_OUT(sclk),
    .VOLATILE_CLR_OUT(vclr), .SCL_OE_OUT(scl_oe), .STATE_OUT(state));
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wait_on(input logic [3:0] s, input int bound);
    int n;
    n = 0;
    while (state !== s && n < bound) begin
      tick();
      n++;
    end
    if (state !== s) begin
      error_cnt++;
      $display("ERROR at %0t: state wait ran out", $time);
      tally_and_finish();
    end
  endtask
  // 32 cycles span exactly two divider periods
  task automatic pulses(output int p);
    p = 0;
    repeat (32) begin
      tick();
      if (sclk === 1'b1) p++;
    end
    tick();
  endtask
  task automatic sc_boot();
    tick();
    chk(14'(state), 14'(ST_OFF));
    chk(14'(ready), 14'h0000);
    sup <= 1'b1;
    wait_on(ST_STANDBY, BOOT_CYCLES + 10);
    tick();
    chk(14'(ready), 14'h0001);
    chk(14'(analog), 14'h0000);
  endtask
  task automatic sc_refuse();
    int p;
    slp_req <= 1'b1;
    pulses(p);
    chk(14'(state), 14'(ST_STANDBY));
    chk(14'(p), 14'h0000);
    slp_req <= 1'b0;
  endtask
  // clear pulse leaves with the state change, one cycle before state is reported
  task automatic sc_active();
    int n;
    n = 0;
    run_req <= 1'b1;
    while (vclr !== 1'b1 && n < 10) begin
      tick();
      n++;
    end
    if (vclr !== 1'b1) begin
      error_cnt++;
      $display("ERROR at %0t: clear pulse wait ran out", $time);
      tally_and_finish();
    end
    chk(14'(vclr), 14'h0001);
    chk(14'(state), 14'(ST_STANDBY));
    tick();
    chk(14'(vclr), 14'h0000);
    chk(14'(state), 14'(ST_WAKE));
    chk(14'(analog), 14'h0001);
    chk(data.x, ZERO_COUNT);
    chk(data.z, ZERO_COUNT);
    chk(14'(valid), 14'h0000);
  endtask
  task automatic fmt(input logic [1:0] r, input logic l, input logic s,
    input logic [13:0] ex, input logic [13:0] ey, input logic [13:0] ez);
    int p;
    rg <= r;
    ln <= l;
    st <= s;
    pulses(p);
    chk(14'(p), 14'h0002);
    chk(data.x, ex);
    chk(data.y, ey);
    chk(data.z, ez);
  endtask
  task automatic sc_format();
    fmt(RANGE_2G, 1'b0, 1'b0, 14'h1000, 14'h3000, ZERO_COUNT);
    fmt(RANGE_4G, 1'b0, 1'b0, 14'h0800, 14'h3800, ZERO_COUNT);
    fmt(RANGE_8G, 1'b0, 1'b0, 14'h0400, 14'h3C00, ZERO_COUNT);
    fmt(RANGE_8G, 1'b1, 1'b0, 14'h0800, 14'h3800, ZERO_COUNT);
    fmt(RANGE_2G, 1'b0, 1'b1, 14'h1100, 14'h3100, 14'h0100);
    fmt(RANGE_4G, 1'b0, 1'b1, 14'h0880, 14'h3880, 14'h0080);
    chk(14'(valid), 14'h0001);
  endtask
  task automatic sc_sleep_standby();
    int p;
    slp_req <= 1'b1;
    wait_on(ST_SLEEP, 10);
    chk(14'(analog), 14'h0001);
    run_req <= 1'b0;
    wait_on(ST_STANDBY, 10);
    // new config in standby must not reach the held data
    st <= 1'b0;
    pulses(p);
    chk(14'(p), 14'h0000);
    chk(14'(analog), 14'h0000);
    chk(14'(ready), 14'h0001);
    chk(data.x, 14'h0880);
    chk(data.z, 14'h0080);
    slp_req <= 1'b0;
  endtask
  task automatic sc_off();
    sup <= 1'b0;
    wait_on(ST_OFF, 10);
    tick();
    chk(14'(ready), 14'h0000);
    chk(14'(stretch), 14'h0000);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    sc_boot();
    sc_refuse();
    sc_active();
    sc_format();
    sc_sleep_standby();
    sc_active();
    sc_off();
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
